/* File: awt_pkg.sv */
// Constants shared by the write and translate command logic
package awt_pkg;
   // ------------------------------------------------------------
   // Task file register indices
   // ------------------------------------------------------------
   localparam logic [3:0] REG_DATA = 4'h0;
   localparam logic [3:0] REG_ERR  = 4'h1;
   localparam logic [3:0] REG_SCNT = 4'h2;
   localparam logic [3:0] REG_SNUM = 4'h3;
   localparam logic [3:0] REG_CYLL = 4'h4;
   localparam logic [3:0] REG_CYLH = 4'h5;
   localparam logic [3:0] REG_DRVH = 4'h6;
   localparam logic [3:0] REG_CMD  = 4'h7;
   localparam logic [3:0] REG_CFG  = 4'h8;
   localparam logic [3:0] REG_MULT = 4'h9;
   localparam logic [3:0] REG_MMAX = 4'hA;

   // ------------------------------------------------------------
   // Opcodes
   // ------------------------------------------------------------
   localparam logic [7:0] CMD_XLAT = 8'h87;
   localparam logic [7:0] CMD_WEAR = 8'hF5;
   localparam logic [7:0] CMD_WBUF = 8'hE8;
   localparam logic [7:0] CMD_WDMA = 8'hCA;
   localparam logic [7:0] CMD_WMUL = 8'hC5;
   localparam logic [7:0] CMD_WMNE = 8'hCD;

   // ------------------------------------------------------------
   // Status and error bit positions, field values
   // ------------------------------------------------------------
   localparam int ST_BSY    = 7;
   localparam int ST_RDY    = 6;
   localparam int ST_DRQ    = 3;
   localparam int ST_ERR    = 0;
   localparam int ER_ABRT   = 2;
   localparam int ER_MEDIA  = 6;
   localparam int CFG_8BIT  = 0;
   localparam logic [7:0] MULT_MAX   = 8'h01;
   localparam logic [7:0] BYTE_ZERO  = 8'h00;
   localparam logic [7:0] ERASED_VAL = 8'hFF;
   localparam logic [7:0] WORD_LAST  = 8'hFF;
   localparam logic [8:0] SEC_MAX    = 9'h100;
   localparam logic [8:0] SEC_ONE    = 9'h001;

   // ------------------------------------------------------------
   // Translation block byte offsets
   // ------------------------------------------------------------
   localparam logic [8:0] XO_CYLH = 9'h000;
   localparam logic [8:0] XO_CYLL = 9'h001;
   localparam logic [8:0] XO_HEAD = 9'h002;
   localparam logic [8:0] XO_SECT = 9'h003;
   localparam logic [8:0] XO_LBA2 = 9'h004;
   localparam logic [8:0] XO_LBA1 = 9'h005;
   localparam logic [8:0] XO_LBA0 = 9'h006;
   localparam logic [8:0] XO_ERAS = 9'h013;
   localparam logic [8:0] XO_HOT2 = 9'h018;
   localparam logic [8:0] XO_HOT1 = 9'h019;
   localparam logic [8:0] XO_HOT0 = 9'h01A;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_NS    = 10;
   localparam int T_BSY_NS  = 400;
   localparam int T_BSY_CYC = T_BSY_NS / CLK_NS;

   typedef enum logic [5:0] {
      S_IDLE = 6'b000001,
      S_BUSY = 6'b000010,
      S_PIOW = 6'b000100,
      S_DMAW = 6'b001000,
      S_PROG = 6'b010000,
      S_XRD  = 6'b100000
   } awt_state_t;
endpackage

/* File: awt_buf_if.sv */
// Sector buffer access bundle
`timescale 1ns/10ps
interface awt_buf_if;
   logic        wrEn;
   logic [7:0]  wrAddr;
   logic [15:0] wrData;
   logic [7:0]  rdAddr;
   logic [15:0] rdData;
   modport ctl (output wrEn, wrAddr, wrData, rdAddr, input rdData);
   modport mem (input wrEn, wrAddr, wrData, rdAddr, output rdData);
endinterface

/* File: awt_sector_buf.sv */
// 512-byte sector buffer, one write and one registered read port
`timescale 1ns/10ps
module awt_sector_buf (
   // Clock
   input wire logic clk,
   // Buffer access
   awt_buf_if.mem   bus
);
   logic [15:0] mem [256];

   always_ff @(posedge clk) begin
      if (bus.wrEn) begin
         mem[bus.wrAddr] <= bus.wrData;
      end
      bus.rdData <= mem[bus.rdAddr];
   end
endmodule

/* File: awt_cmd_top.sv */
// Write and sector translation command interpreter of the task file controller
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module awt_cmd_top (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // Task file register port
   input  wire logic [3:0]  regAddr,
   input  wire logic [15:0] regWrData,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic      [15:0] regRdData,
   // Host interrupt line
   output logic             intrq,
   // DMA handshake
   output logic             dmaReq,
   input  wire logic        dmaAckN,
   input  wire logic        dmaWrStb,
   input  wire logic [15:0] dmaData,
   // Flash programming handshake
   output logic             flashReq,
   output logic      [27:0] flashLba,
   output logic             flashNoErase,
   input  wire logic        flashAck,
   input  wire logic        flashErr,
   input  wire logic [7:0]  flashBufAddr,
   output logic      [15:0] flashBufData,
   // Sector translation data from media manager
   input  wire logic [15:0] xlatCyl,
   input  wire logic [3:0]  xlatHead,
   input  wire logic [7:0]  xlatSec,
   input  wire logic        xlatErased,
   input  wire logic [23:0] xlatHotCount
);
   awt_pkg::awt_state_t state_reg;
   logic [7:0]  cmd_reg;
   logic [7:0]  secCnt_reg;
   logic [7:0]  secNum_reg;
   logic [7:0]  cylLo_reg;
   logic [7:0]  cylHi_reg;
   logic [7:0]  drvHead_reg;
   logic [7:0]  errReg_reg;
   logic        bsy_reg;
   logic        drq_reg;
   logic        errBit_reg;
   logic        intrq_reg;
   logic        cfg8_reg;
   logic [7:0]  multCnt_reg;
   logic [7:0]  wordIdx_reg;
   logic [8:0]  secLeft_reg;
   logic [8:0]  blkLeft_reg;
   logic        dmaReq_reg;
   logic        flashReq_reg;
   logic [27:0] flashLba_reg;
   logic        noErase_reg;
   logic [15:0] rdData_reg;

   awt_buf_if buf_if ();

   awt_sector_buf u_buf (
      .clk (clk),
      .bus (buf_if.mem)
   );

   // ------------------------------------------------------------
   // Decoding
   // ------------------------------------------------------------
   wire        stIdle    = (state_reg == awt_pkg::S_IDLE);
   wire        stPioW    = (state_reg == awt_pkg::S_PIOW);
   wire        stDmaW    = (state_reg == awt_pkg::S_DMAW);
   wire        stXrd     = (state_reg == awt_pkg::S_XRD);
   wire        taskWrOk  = regWr && stIdle;
   wire        cmdAccept = taskWrOk && (regAddr == awt_pkg::REG_CMD);
   wire        dataWr    = regWr && (regAddr == awt_pkg::REG_DATA) && stPioW && drq_reg;
   wire        dataRd    = regRd && (regAddr == awt_pkg::REG_DATA) && stXrd && drq_reg;
   wire        dmaWord   = stDmaW && dmaReq_reg && !dmaAckN && dmaWrStb;
   wire        statusRd  = regRd && (regAddr == awt_pkg::REG_CMD);
   wire        lastWord  = (wordIdx_reg == awt_pkg::WORD_LAST);
   wire        multEn    = (multCnt_reg != awt_pkg::BYTE_ZERO);
   wire        isMult    = (cmd_reg == awt_pkg::CMD_WMUL) || (cmd_reg == awt_pkg::CMD_WMNE);
   wire [27:0] curLba    = {drvHead_reg[3:0], cylHi_reg, cylLo_reg, secNum_reg};
   wire [27:0] lbaNext   = curLba + 28'h0000001;
   // Zero count means the full 256 sectors
   wire [8:0]  secTotal  = (secCnt_reg == awt_pkg::BYTE_ZERO) ? awt_pkg::SEC_MAX
                                                              : {1'b0, secCnt_reg};
   wire [8:0]  secLeftDec = secLeft_reg - awt_pkg::SEC_ONE;
   wire [8:0]  multSize   = {1'b0, multCnt_reg};
   // Full blocks first, leftover forms the final partial block
   wire [8:0]  blkFirst   = (secTotal < multSize) ? secTotal : multSize;
   wire [8:0]  blkNext    = (secLeftDec < multSize) ? secLeftDec : multSize;

   assign buf_if.wrEn   = dataWr || dmaWord;
   assign buf_if.wrAddr = wordIdx_reg;
   assign buf_if.wrData = dmaWord ? dmaData : regWrData;
   assign buf_if.rdAddr = flashBufAddr;

   // ------------------------------------------------------------
   // Translation block contents
   // ------------------------------------------------------------
   // Sources passed as arguments so the word follows every one of them
   function automatic logic [7:0] xlatByte(input logic [8:0]  off,
                                           input logic [15:0] cyl,
                                           input logic [3:0]  head,
                                           input logic [7:0]  sec,
                                           input logic        erased,
                                           input logic [23:0] hot,
                                           input logic [27:0] lba);
      logic [7:0] b;
      b = awt_pkg::BYTE_ZERO;
      if (off == awt_pkg::XO_CYLH) begin
         b = cyl[15:8];
      end else if (off == awt_pkg::XO_CYLL) begin
         b = cyl[7:0];
      end else if (off == awt_pkg::XO_HEAD) begin
         b = {4'h0, head};
      end else if (off == awt_pkg::XO_SECT) begin
         b = sec;
      end else if (off == awt_pkg::XO_LBA2) begin
         b = lba[23:16];
      end else if (off == awt_pkg::XO_LBA1) begin
         b = lba[15:8];
      end else if (off == awt_pkg::XO_LBA0) begin
         b = lba[7:0];
      end else if (off == awt_pkg::XO_ERAS) begin
         b = erased ? awt_pkg::ERASED_VAL : awt_pkg::BYTE_ZERO;
      end else if (off == awt_pkg::XO_HOT2) begin
         b = hot[23:16];
      end else if (off == awt_pkg::XO_HOT1) begin
         b = hot[15:8];
      end else if (off == awt_pkg::XO_HOT0) begin
         b = hot[7:0];
      end
      return b;
   endfunction

   // Low byte carries the even offset, as on the data register
   wire [7:0]  xlatHi = xlatByte({wordIdx_reg, 1'b1}, xlatCyl, xlatHead, xlatSec, xlatErased, xlatHotCount, curLba);
   wire [7:0]  xlatLo = xlatByte({wordIdx_reg, 1'b0}, xlatCyl, xlatHead, xlatSec, xlatErased, xlatHotCount, curLba);
   wire [15:0] xlatWord = {xlatHi, xlatLo};
   wire [7:0]  statusByte = {bsy_reg, !bsy_reg, 2'b00, drq_reg, 2'b00, errBit_reg};

   wire [15:0] rdMux =
      (regAddr == awt_pkg::REG_DATA) ? (stXrd ? xlatWord : 16'h0000) :
      (regAddr == awt_pkg::REG_ERR)  ? {8'h00, errReg_reg} :
      (regAddr == awt_pkg::REG_SCNT) ? {8'h00, secCnt_reg} :
      (regAddr == awt_pkg::REG_SNUM) ? {8'h00, secNum_reg} :
      (regAddr == awt_pkg::REG_CYLL) ? {8'h00, cylLo_reg} :
      (regAddr == awt_pkg::REG_CYLH) ? {8'h00, cylHi_reg} :
      (regAddr == awt_pkg::REG_DRVH) ? {8'h00, drvHead_reg} :
      (regAddr == awt_pkg::REG_CMD)  ? {8'h00, statusByte} :
      (regAddr == awt_pkg::REG_CFG)  ? {15'h0000, cfg8_reg} :
      (regAddr == awt_pkg::REG_MULT) ? {8'h00, multCnt_reg} :
      (regAddr == awt_pkg::REG_MMAX) ? {8'h00, awt_pkg::MULT_MAX} :
      16'h0000;

   always_ff @(posedge clk) begin
      if (srst) begin
         rdData_reg <= 16'h0000;
      end else if (regRd) begin
         rdData_reg <= rdMux;
      end
   end

   // ------------------------------------------------------------
   // Command sequencer
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         state_reg    <= awt_pkg::S_IDLE;
         cmd_reg      <= 8'h00;
         secCnt_reg   <= 8'h00;
         secNum_reg   <= 8'h00;
         cylLo_reg    <= 8'h00;
         cylHi_reg    <= 8'h00;
         drvHead_reg  <= 8'h00;
         errReg_reg   <= 8'h00;
         bsy_reg      <= 1'b0;
         drq_reg      <= 1'b0;
         errBit_reg   <= 1'b0;
         intrq_reg    <= 1'b0;
         cfg8_reg     <= 1'b0;
         multCnt_reg  <= 8'h00;
         wordIdx_reg  <= 8'h00;
         secLeft_reg  <= 9'h000;
         blkLeft_reg  <= 9'h000;
         dmaReq_reg   <= 1'b0;
         flashReq_reg <= 1'b0;
         flashLba_reg <= 28'h0000000;
         noErase_reg  <= 1'b0;
      end else begin
         // Status read drops the line; a same-cycle event below wins
         if (statusRd) begin
            intrq_reg <= 1'b0;
         end
         if (taskWrOk) begin
            if (regAddr == awt_pkg::REG_SCNT) begin
               secCnt_reg <= regWrData[7:0];
            end else if (regAddr == awt_pkg::REG_SNUM) begin
               secNum_reg <= regWrData[7:0];
            end else if (regAddr == awt_pkg::REG_CYLL) begin
               cylLo_reg <= regWrData[7:0];
            end else if (regAddr == awt_pkg::REG_CYLH) begin
               cylHi_reg <= regWrData[7:0];
            end else if (regAddr == awt_pkg::REG_DRVH) begin
               drvHead_reg <= regWrData[7:0];
            end else if (regAddr == awt_pkg::REG_CFG) begin
               cfg8_reg <= regWrData[awt_pkg::CFG_8BIT];
            end else if (regAddr == awt_pkg::REG_MULT) begin
               // Unsupported sizes leave multiple mode disabled
               multCnt_reg <= (regWrData[7:0] == awt_pkg::MULT_MAX) ? awt_pkg::MULT_MAX : 8'h00;
            end
         end
         case (state_reg)
            awt_pkg::S_IDLE: begin
               if (cmdAccept) begin
                  cmd_reg    <= regWrData[7:0];
                  bsy_reg    <= 1'b1;
                  errBit_reg <= 1'b0;
                  errReg_reg <= 8'h00;
                  intrq_reg  <= 1'b0;
                  state_reg  <= awt_pkg::S_BUSY;
               end
            end
            awt_pkg::S_BUSY: begin
               wordIdx_reg <= 8'h00;
               if (cmd_reg == awt_pkg::CMD_XLAT) begin
                  bsy_reg   <= 1'b0;
                  drq_reg   <= 1'b1;
                  intrq_reg <= 1'b1;
                  state_reg <= awt_pkg::S_XRD;
               end else if (cmd_reg == awt_pkg::CMD_WEAR) begin
                  secCnt_reg <= 8'h00;
                  bsy_reg    <= 1'b0;
                  intrq_reg  <= 1'b1;
                  state_reg  <= awt_pkg::S_IDLE;
               end else if (cmd_reg == awt_pkg::CMD_WBUF) begin
                  secLeft_reg <= awt_pkg::SEC_ONE;
                  bsy_reg     <= 1'b0;
                  drq_reg     <= 1'b1;
                  state_reg   <= awt_pkg::S_PIOW;
               end else if ((cmd_reg == awt_pkg::CMD_WDMA) && !cfg8_reg) begin
                  // Busy held through the whole transfer
                  secLeft_reg <= secTotal;
                  dmaReq_reg  <= 1'b1;
                  state_reg   <= awt_pkg::S_DMAW;
               end else if (isMult && multEn) begin
                  secLeft_reg <= secTotal;
                  blkLeft_reg <= blkFirst;
                  noErase_reg <= (cmd_reg == awt_pkg::CMD_WMNE);
                  bsy_reg     <= 1'b0;
                  drq_reg     <= 1'b1;
                  state_reg   <= awt_pkg::S_PIOW;
               end else begin
                  // 8-bit DMA, unset multiple mode and unknown opcodes
                  errBit_reg <= 1'b1;
                  errReg_reg <= 8'h01 << awt_pkg::ER_ABRT;
                  bsy_reg    <= 1'b0;
                  intrq_reg  <= 1'b1;
                  state_reg  <= awt_pkg::S_IDLE;
               end
            end
            awt_pkg::S_PIOW: begin
               if (dataWr) begin
                  wordIdx_reg <= wordIdx_reg + 8'h01;
                  if (lastWord) begin
                     drq_reg <= 1'b0;
                     if (cmd_reg == awt_pkg::CMD_WBUF) begin
                        intrq_reg <= 1'b1;
                        state_reg <= awt_pkg::S_IDLE;
                     end else begin
                        bsy_reg      <= 1'b1;
                        flashReq_reg <= 1'b1;
                        flashLba_reg <= curLba;
                        state_reg    <= awt_pkg::S_PROG;
                     end
                  end
               end
            end
            awt_pkg::S_DMAW: begin
               if (dmaWord) begin
                  wordIdx_reg <= wordIdx_reg + 8'h01;
                  if (lastWord) begin
                     dmaReq_reg   <= 1'b0;
                     flashReq_reg <= 1'b1;
                     flashLba_reg <= curLba;
                     state_reg    <= awt_pkg::S_PROG;
                  end
               end
            end
            awt_pkg::S_PROG: begin
               if (flashAck) begin
                  flashReq_reg <= 1'b0;
                  wordIdx_reg  <= 8'h00;
                  if (flashErr) begin
                     // Address and count left pointing at the failed sector
                     errBit_reg <= 1'b1;
                     errReg_reg <= 8'h01 << awt_pkg::ER_MEDIA;
                     bsy_reg    <= 1'b0;
                     intrq_reg  <= 1'b1;
                     state_reg  <= awt_pkg::S_IDLE;
                  end else begin
                     secNum_reg       <= lbaNext[7:0];
                     cylLo_reg        <= lbaNext[15:8];
                     cylHi_reg        <= lbaNext[23:16];
                     drvHead_reg[3:0] <= lbaNext[27:24];
                     secCnt_reg       <= secCnt_reg - 8'h01;
                     secLeft_reg      <= secLeftDec;
                     if (secLeft_reg == awt_pkg::SEC_ONE) begin
                        bsy_reg   <= 1'b0;
                        intrq_reg <= 1'b1;
                        state_reg <= awt_pkg::S_IDLE;
                     end else if (cmd_reg == awt_pkg::CMD_WDMA) begin
                        dmaReq_reg <= 1'b1;
                        state_reg  <= awt_pkg::S_DMAW;
                     end else begin
                        bsy_reg   <= 1'b0;
                        drq_reg   <= 1'b1;
                        state_reg <= awt_pkg::S_PIOW;
                        if (blkLeft_reg == awt_pkg::SEC_ONE) begin
                           blkLeft_reg <= blkNext;
                           intrq_reg   <= 1'b1;
                        end else begin
                           blkLeft_reg <= blkLeft_reg - awt_pkg::SEC_ONE;
                        end
                     end
                  end
               end
            end
            awt_pkg::S_XRD: begin
               if (dataRd) begin
                  wordIdx_reg <= wordIdx_reg + 8'h01;
                  if (lastWord) begin
                     drq_reg   <= 1'b0;
                     state_reg <= awt_pkg::S_IDLE;
                  end
               end
            end
            default: begin
               state_reg <= awt_pkg::S_IDLE;
            end
         endcase
      end
   end

   assign regRdData    = rdData_reg;
   assign intrq        = intrq_reg;
   assign dmaReq       = dmaReq_reg;
   assign flashReq     = flashReq_reg;
   assign flashLba     = flashLba_reg;
   assign flashNoErase = noErase_reg;
   assign flashBufData = buf_if.rdData;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   localparam int BSY_CYC = awt_pkg::T_BSY_CYC;
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence seq_start(logic [7:0] op);
      cmdAccept && (regWrData[7:0] == op);
   endsequence
   sequence seq_abort;
      errBit_reg && errReg_reg[awt_pkg::ER_ABRT] && stIdle && !bsy_reg && intrq_reg;
   endsequence

   a_mult_busy_time: assert property (seq_start(awt_pkg::CMD_WMUL) |-> ##[1:BSY_CYC] bsy_reg)
      else $error("busy not set in time after multiple write");
   a_xlat_drq_up: assert property (seq_start(awt_pkg::CMD_XLAT) |-> ##2 (drq_reg && stXrd && !bsy_reg))
      else $error("translation data request missing");
   a_wear_count_zero: assert property (seq_start(awt_pkg::CMD_WEAR) |-> ##2 (secCnt_reg == 8'h00 && stIdle))
      else $error("wear level left nonzero count");
   a_dma_eight_abort: assert property (seq_start(awt_pkg::CMD_WDMA) ##0 cfg8_reg |-> ##2 seq_abort)
      else $error("dma write not aborted in 8-bit mode");
   a_mult_unset_abort: assert property (seq_start(awt_pkg::CMD_WMUL) ##0 !multEn |-> ##2 seq_abort)
      else $error("multiple write not aborted when disabled");
   a_dma_busy_held: assert property (dmaReq_reg |-> (bsy_reg && !drq_reg))
      else $error("dma request without busy");
   a_dma_no_irq: assert property ((stDmaW || $past(stDmaW)) |-> !$rose(intrq_reg))
      else $error("interrupt during dma transfer");
   a_err_hold_addr: assert property ((state_reg == awt_pkg::S_PROG) && flashAck && flashErr
      |=> (secCnt_reg == $past(secCnt_reg)) && (curLba == $past(curLba)) && errBit_reg)
      else $error("error did not keep failing sector");
   a_block_limit: assert property (multCnt_reg <= awt_pkg::MULT_MAX)
      else $error("block count above supported size");
   a_dma_zero_full: assert property (seq_start(awt_pkg::CMD_WDMA) ##0 (secCnt_reg == 8'h00) && !cfg8_reg
      |-> ##2 (secLeft_reg == awt_pkg::SEC_MAX))
      else $error("zero count not taken as 256");
endmodule

/* File: awt_flash_model.sv */
// Flash programming responder that answers the sector program requests
`timescale 1ns/10ps
module awt_flash_model (
   // Clock
   input  wire logic clk,
   // Program handshake
   input  wire logic flashReq,
   input  wire logic fail,
   output logic      flashAck = 1'b0,
   output logic      flashErr = 1'b0
);
   logic [3:0] dlyReg = 4'h0;
   // Slow answer; error line flips while not qualified
   always_ff @(posedge clk) begin
      dlyReg   <= (flashReq && !flashAck) ? dlyReg + 4'h1 : 4'h0;
      flashAck <= flashReq && !flashAck && dlyReg == 4'h7;
      flashErr <= (flashReq && dlyReg == 4'h7) ? fail : ~flashErr;
   end
endmodule

/* File: awt_cmd_top_test.sv */
// Self-checking bench for the write and translate command logic
`timescale 1ns/10ps
module awt_cmd_top_test;
   logic clk = 0, srst = 1, regWr = 0, regRd = 0, dmaAckN = 1, dmaWrStb = 0, ers = 1, fail = 0;
   logic intrq, dmaReq, flashReq, flashAck, flashErr, flashNoErase;
   logic [3:0] regAddr = 4'h0;
   logic [15:0] regWrData = 16'h0, dmaData = 16'h0, regRdData, r, w [256];
   logic [27:0] flashLba;
   logic [7:0] bufAddr = 8'h0;
   logic [15:0] bufData;
   int err_count = 0, n_compared = 0;
   initial forever #5 clk = ~clk;
   awt_cmd_top u_awt_cmd_top (.clk(clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
      .regRd(regRd), .regRdData(regRdData), .intrq(intrq), .dmaReq(dmaReq), .dmaAckN(dmaAckN), .dmaWrStb(dmaWrStb),
      .dmaData(dmaData), .flashReq(flashReq), .flashLba(flashLba), .flashNoErase(flashNoErase), .flashAck(flashAck),
      .flashErr(flashErr), .flashBufAddr(bufAddr), .flashBufData(bufData), .xlatCyl(16'hABCD), .xlatHead(4'h5),
      .xlatSec(8'h21), .xlatErased(ers), .xlatHotCount(24'h10203));
   awt_flash_model u_awt_flash_model (.clk(clk), .flashReq(flashReq), .fail(fail), .flashAck(flashAck),
      .flashErr(flashErr));
   task chk(input logic [15:0] g, e);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task wrap_up;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task rd(input logic [3:0] a);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 r = regRdData;
   endtask
   task rc(input logic [3:0] a, input logic [7:0] e);
      rd(a);
      chk({8'h0, r[7:0]}, {8'h0, e});
   endtask
   // Bounded wait on interrupt (0) or DMA request (1)
   task automatic wt(input bit k);
      int n = 0;
      #1;
      while ((k ? dmaReq : intrq) !== 1'b1) begin
         @(posedge clk);
         #1;
         if (++n > 3000) begin
            err_count++;
            wrap_up();
         end
      end
   endtask
   task pio;
      for (int i = 0; i < 256; i++) wr(4'h0, 16'(i));
   endtask
   task dsec;
      wt(1);
      @(posedge clk);
      dmaAckN <= 1'b0;
      for (int i = 0; i < 256; i++) begin
         @(posedge clk);
         dmaWrStb <= 1'b1;
         dmaData <= 16'(i);
         @(posedge clk);
         dmaWrStb <= 1'b0;
      end
      @(posedge clk);
      dmaAckN <= 1'b1;
   endtask
   task t_abort;
      wr(4'h8, 16'h1);
      foreach (w[i]) if (i < 2) begin
         wr(4'h7, i ? 16'hCA : 16'hC5);
         wt(0);
         rc(4'h1, 8'h04);
         rc(4'h7, 8'h41);
      end
      wr(4'h8, 16'h0);
      $display("abort done");
   endtask
   task t_xlat;
      wr(4'h4, 16'h34);
      wr(4'h5, 16'h12);
      wr(4'h3, 16'h56);
      wr(4'h6, 16'hE3);
      wr(4'h7, 16'h87);
      wt(0);
      rc(4'h7, 8'h48);
      for (int i = 0; i < 256; i++) begin
         rd(4'h0);
         w[i] = r;
      end
      chk(w[0], 16'hCDAB);
      chk(w[1], 16'h2105);
      chk(w[2], 16'h3412);
      chk(w[3] & 16'hFF, 16'h56);
      chk(w[9] & 16'hFF00, 16'hFF00);
      chk(w[12], 16'h0201);
      chk(w[13] & 16'hFF, 16'h03);
      rc(4'h7, 8'h40);
      $display("xlat done");
   endtask
   task t_misc;
      wr(4'h2, 16'h5);
      wr(4'h7, 16'hF5);
      wt(0);
      rc(4'h2, 8'h00);
      rc(4'h7, 8'h40);
      wr(4'h7, 16'hE8);
      rc(4'h7, 8'h48);
      pio;
      wt(0);
      rc(4'h7, 8'h40);
      @(posedge clk);
      bufAddr <= 8'h7F;
      repeat (2) @(posedge clk);
      #1 chk(bufData, 16'h007F);
      $display("misc done");
   endtask
   task t_dma;
      wr(4'h2, 16'h2);
      wr(4'h3, 16'h20);
      wr(4'h7, 16'hCA);
      wt(1);
      rc(4'h7, 8'h80);
      dsec;
      wt(1);
      chk(16'(intrq), 16'h0);
      dsec;
      wt(0);
      rc(4'h7, 8'h40);
      rc(4'h3, 8'h22);
      $display("dma done");
   endtask
   task t_mult;
      wr(4'h9, 16'h2);
      rc(4'h9, 8'h00);
      wr(4'h9, 16'h1);
      rc(4'hA, 8'h01);
      wr(4'h3, 16'h0A);
      wr(4'h2, 16'h2);
      wr(4'h7, 16'hCD);
      repeat (2) @(posedge clk);
      #1 chk(16'(intrq), 16'h0);
      rc(4'h7, 8'h48);
      pio;
      repeat (2) @(posedge clk);
      chk({flashLba[15:0]}, 16'h340A);
      chk(16'(flashNoErase), 16'h1);
      chk(16'(flashReq), 16'h1);
      wt(0);
      rc(4'h7, 8'h48);
      fail = 1'b1;
      pio;
      wt(0);
      rc(4'h7, 8'h41);
      rc(4'h1, 8'h40);
      rc(4'h2, 8'h01);
      rc(4'h3, 8'h0B);
      fail = 1'b0;
      wr(4'h2, 16'h1);
      wr(4'h7, 16'hC5);
      pio;
      repeat (2) @(posedge clk);
      chk(16'(flashNoErase), 16'h0);
      wt(0);
      rc(4'h7, 8'h40);
      $display("mult done");
   endtask
   task t_reset;
      wr(4'h2, 16'h0);
      wr(4'h7, 16'hCA);
      wt(1);
      rc(4'h7, 8'h80);
      @(posedge clk);
      srst <= 1'b1;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      #1 chk({14'h0, intrq, dmaReq}, 16'h0);
      rc(4'h7, 8'h40);
      rc(4'h9, 8'h00);
      $display("reset done");
   endtask
   initial begin
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      t_abort;
      t_xlat;
      t_misc;
      t_dma;
      t_mult;
      t_reset;
      wrap_up;
   end
endmodule
